// ---- core/data_bus_port_pair.v ----
`timescale 1ns/100ps
`default_nettype none
`include "dbus_port_defs.vh"
module data_bus_port_pair #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire nrst,
  // Register port
  input wire [15:0] reg_addr,
  input wire [WIDTH-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [WIDTH-1:0] reg_rdata,
  // Mode and standby
  input wire [2:0] mode_pins,
  input wire hw_standby,
  input wire sw_standby,
  input wire bus16_sel,
  // Bus controller data path
  input wire [2*WIDTH-1:0] dbus_out_data,
  input wire dbus_drive,
  output wire [2*WIDTH-1:0] dbus_in_data,
  // High lane pins
  input wire [WIDTH-1:0] hi_lane_pins_in,
  output wire [WIDTH-1:0] hi_lane_pins_out,
  output wire [WIDTH-1:0] hi_lane_pins_oe_n,
  output wire [WIDTH-1:0] hi_lane_pullup_on,
  // Low lane pins
  input wire [WIDTH-1:0] lo_lane_pins_in,
  output wire [WIDTH-1:0] lo_lane_pins_out,
  output wire [WIDTH-1:0] lo_lane_pins_oe_n,
  output wire [WIDTH-1:0] lo_lane_pullup_on,
  // Mode view
  output reg hi_lane_bus_mode,
  output reg lo_lane_bus_mode
);

  //////////////////////////////////////////////////////////////////////////
  // Mode decode helpers
  function ext_mode;
    input [2:0] m;
    begin
      ext_mode = (m >= `MODE_EXT_FIRST) && (m <= `MODE_EXT_LAST);
    end
  endfunction

  function single_mode;
    input [2:0] m;
    begin
      single_mode = (m == `MODE_SINGLE_CHIP);
    end
  endfunction

  // Low lane owned by the data path only on a wide bus
  function lo_on_bus;
    input [2:0] m;
    input wide;
    begin
      lo_on_bus = ext_mode(m) & wide;
    end
  endfunction

  // Low lane pull-ups also live in narrow external modes
  function lo_pullup_mode;
    input [2:0] m;
    input wide;
    begin
      lo_pullup_mode = single_mode(m) | (ext_mode(m) & ~wide);
    end
  endfunction

  // Full 16-bit compare; no partial decode, so no aliases
  function addr_hit;
    input [15:0] a;
    input [15:0] offset;
    begin
      addr_hit = (a == offset);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin-level inputs cross two flops first
  reg [2:0] mode_meta;
  reg [2:0] mode_sync;
  reg hw_stby_meta;
  reg hw_stby_sync;

  // Mode pins settle at power-up; two flops ride out a change
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      mode_meta <= 3'h0;
      mode_sync <= 3'h0;
    end
    else
    begin
      mode_meta <= mode_pins;
      mode_sync <= mode_meta;
    end
  end

  // Standby pin may rise at any time
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      hw_stby_meta <= 1'b0;
      hw_stby_sync <= 1'b0;
    end
    else
    begin
      hw_stby_meta <= hw_standby;
      hw_stby_sync <= hw_stby_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Lane ownership and pull-up permission
  wire is_ext;
  wire is_single;
  wire hi_bus;
  wire lo_bus;
  wire hi_pu_ok;
  wire lo_pu_ok;

  assign is_ext = ext_mode(mode_sync);
  assign is_single = single_mode(mode_sync);
  // Direction ignored by driver and pull-up whenever the lane carries data; pin view still uses it
  assign hi_bus = is_ext;
  assign lo_bus = lo_on_bus(mode_sync, bus16_sel);
  assign hi_pu_ok = is_single;
  assign lo_pu_ok = lo_pullup_mode(mode_sync, bus16_sel);

  // Registered copies let software-free logic watch ownership
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      hi_lane_bus_mode <= 1'b0;
      lo_lane_bus_mode <= 1'b0;
    end
    else
    begin
      hi_lane_bus_mode <= hi_bus;
      lo_lane_bus_mode <= lo_bus;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address decode
  wire hit_hi_dir;
  wire hit_hi_latch;
  wire hit_hi_view;
  wire hit_hi_pu;
  wire hit_lo_dir;
  wire hit_lo_latch;
  wire hit_lo_view;
  wire hit_lo_pu;

  assign hit_hi_dir = addr_hit(reg_addr, `HI_LANE_DIRECTION_ADDR);
  assign hit_hi_latch = addr_hit(reg_addr, `HI_LANE_LATCH_ADDR);
  assign hit_hi_view = addr_hit(reg_addr, `HI_LANE_PIN_VIEW_ADDR);
  assign hit_hi_pu = addr_hit(reg_addr, `HI_LANE_PULLUP_ADDR);

  // Low lane offsets sit one above the high ones
  assign hit_lo_dir = addr_hit(reg_addr, `LO_LANE_DIRECTION_ADDR);
  assign hit_lo_latch = addr_hit(reg_addr, `LO_LANE_LATCH_ADDR);
  assign hit_lo_view = addr_hit(reg_addr, `LO_LANE_PIN_VIEW_ADDR);
  assign hit_lo_pu = addr_hit(reg_addr, `LO_LANE_PULLUP_ADDR);

  //////////////////////////////////////////////////////////////////////////
  // Software registers
  reg [WIDTH-1:0] hi_lane_direction;
  reg [WIDTH-1:0] hi_lane_output_latch;
  reg [WIDTH-1:0] hi_lane_pullup_control;
  reg [WIDTH-1:0] lo_lane_direction;
  reg [WIDTH-1:0] lo_lane_output_latch;
  reg [WIDTH-1:0] lo_lane_pullup_control;

  // Hardware standby acts as reset; software standby leaves these registers writable
  always @(posedge core_clk)
  begin
    if (!nrst || hw_stby_sync)
    begin
      hi_lane_direction <= `LANE_REG_RESET;
      hi_lane_output_latch <= `LANE_REG_RESET;
      hi_lane_pullup_control <= `LANE_REG_RESET;
    end
    else if (reg_wr)
    begin
      if (hit_hi_dir)
        hi_lane_direction <= reg_wdata;
      if (hit_hi_latch)
        hi_lane_output_latch <= reg_wdata;
      if (hit_hi_pu)
        hi_lane_pullup_control <= reg_wdata;
      // Pin view offset takes no write
    end
  end

  // Low lane kept apart; its ownership also hangs on bus width
  always @(posedge core_clk)
  begin
    if (!nrst || hw_stby_sync)
    begin
      lo_lane_direction <= `LANE_REG_RESET;
      lo_lane_output_latch <= `LANE_REG_RESET;
      lo_lane_pullup_control <= `LANE_REG_RESET;
    end
    else if (reg_wr)
    begin
      if (hit_lo_dir)
        lo_lane_direction <= reg_wdata;
      if (hit_lo_latch)
        lo_lane_output_latch <= reg_wdata;
      if (hit_lo_pu)
        lo_lane_pullup_control <= reg_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Lane pin logic
  wire [WIDTH-1:0] hi_view;
  wire [WIDTH-1:0] lo_view;

  lane_pin_cell #(
    .WIDTH(WIDTH)
  ) u_hi_lane (
    .core_clk(core_clk),
    .nrst(nrst),
    .clear(hw_stby_sync),
    .freeze(sw_standby),
    .bus_owns(hi_bus),
    .pullup_allowed(hi_pu_ok),
    .direction(hi_lane_direction),
    .latch(hi_lane_output_latch),
    .pullup_ctl(hi_lane_pullup_control),
    .pins_in(hi_lane_pins_in),
    .bus_out(dbus_out_data[2*WIDTH-1:WIDTH]),
    .bus_drive(dbus_drive),
    .pins_out(hi_lane_pins_out),
    .pins_oe_n(hi_lane_pins_oe_n),
    .pullup_on(hi_lane_pullup_on),
    .pin_view(hi_view),
    .bus_in(dbus_in_data[2*WIDTH-1:WIDTH])
  );

  lane_pin_cell #(
    .WIDTH(WIDTH)
  ) u_lo_lane (
    .core_clk(core_clk),
    .nrst(nrst),
    .clear(hw_stby_sync),
    .freeze(sw_standby),
    .bus_owns(lo_bus),
    .pullup_allowed(lo_pu_ok),
    .direction(lo_lane_direction),
    .latch(lo_lane_output_latch),
    .pullup_ctl(lo_lane_pullup_control),
    .pins_in(lo_lane_pins_in),
    .bus_out(dbus_out_data[WIDTH-1:0]),
    .bus_drive(dbus_drive),
    .pins_out(lo_lane_pins_out),
    .pins_oe_n(lo_lane_pins_oe_n),
    .pullup_on(lo_lane_pullup_on),
    .pin_view(lo_view),
    .bus_in(dbus_in_data[WIDTH-1:0])
  );

  //////////////////////////////////////////////////////////////////////////
  // Read mux; write-only direction reads a fixed filler
  reg [WIDTH-1:0] next_rdata;

  always @*
  begin
    next_rdata = `UNDEFINED_READ;
    if (reg_rd)
    begin
      if (hit_hi_latch)
        next_rdata = hi_lane_output_latch;
      else if (hit_hi_view)
        next_rdata = hi_view;
      else if (hit_hi_pu)
        next_rdata = hi_lane_pullup_control;
      else if (hit_lo_latch)
        next_rdata = lo_lane_output_latch;
      else if (hit_lo_view)
        next_rdata = lo_view;
      else if (hit_lo_pu)
        next_rdata = lo_lane_pullup_control;
      else
        next_rdata = `UNDEFINED_READ;
    end
  end

  // Data stand only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    if (!nrst)
      reg_rdata <= `UNDEFINED_READ;
    else
      reg_rdata <= next_rdata;
  end

endmodule // data_bus_port_pair
`default_nettype wire

// ---- core/dbus_port_defs.vh ----
`ifndef DBUS_PORT_DEFS_VH
`define DBUS_PORT_DEFS_VH

// Register offsets, lower 16 address bits
`define HI_LANE_DIRECTION_ADDR 16'hFEBC
`define HI_LANE_LATCH_ADDR 16'hFF6C
`define HI_LANE_PIN_VIEW_ADDR 16'hFF5C
`define HI_LANE_PULLUP_ADDR 16'hFF73
`define LO_LANE_DIRECTION_ADDR 16'hFEBD
`define LO_LANE_LATCH_ADDR 16'hFF6D
`define LO_LANE_PIN_VIEW_ADDR 16'hFF5D
`define LO_LANE_PULLUP_ADDR 16'hFF74

// Reset values
`define LANE_REG_RESET 8'h00
// Returned for write-only and unmapped reads
`define UNDEFINED_READ 8'h00

// Operating modes
`define MODE_EXT_FIRST 3'h4
`define MODE_EXT_LAST 3'h6
`define MODE_SINGLE_CHIP 3'h7

`endif

// ---- core/lane_pin_cell.v ----
`timescale 1ns/100ps
`default_nettype none
module lane_pin_cell #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire nrst,
  input wire clear,
  input wire freeze,
  input wire bus_owns,
  input wire pullup_allowed,
  input wire [WIDTH-1:0] direction,
  input wire [WIDTH-1:0] latch,
  input wire [WIDTH-1:0] pullup_ctl,
  input wire [WIDTH-1:0] pins_in,
  input wire [WIDTH-1:0] bus_out,
  input wire bus_drive,
  output reg [WIDTH-1:0] pins_out,
  output reg [WIDTH-1:0] pins_oe_n,
  output reg [WIDTH-1:0] pullup_on,
  output reg [WIDTH-1:0] pin_view,
  output reg [WIDTH-1:0] bus_in
);

  // Two-stage synchroniser; only stage two feeds logic
  reg [WIDTH-1:0] pin_meta;
  reg [WIDTH-1:0] pin_sync;

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pin_meta <= {WIDTH{1'b0}};
      pin_sync <= {WIDTH{1'b0}};
    end
    else
    begin
      pin_meta <= pins_in;
      pin_sync <= pin_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-pin drive, pull-up and readback
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_pin
      always @(posedge core_clk)
      begin
        if (!nrst || clear)
        begin
          pins_out[i] <= 1'b0;
          pins_oe_n[i] <= 1'b1;
          pullup_on[i] <= 1'b0;
          // Standby clears direction, so the view follows the pin
          pin_view[i] <= clear & nrst & pin_sync[i];
        end
        else
        begin
          // Bus owns the driver; latch and direction kept and still steer the pin view
          if (bus_owns)
          begin
            pins_out[i] <= bus_out[i];
            pins_oe_n[i] <= ~bus_drive;
          end
          else
          begin
            pins_out[i] <= latch[i];
            pins_oe_n[i] <= ~direction[i];
          end
          // Pull-up never on for driven or bus pins
          pullup_on[i] <= pullup_allowed & ~bus_owns & ~direction[i]
            & pullup_ctl[i];
          // Frozen in software standby so software sees last state
          if (!freeze)
            pin_view[i] <= direction[i] ? latch[i] : pin_sync[i];
        end
      end
    end
  endgenerate

  // Sampled pin levels go to the data path
  always @(posedge core_clk)
  begin
    if (!nrst)
      bus_in <= {WIDTH{1'b0}};
    else
      bus_in <= pin_sync;
  end

endmodule // lane_pin_cell
`default_nettype wire

// ---- tb/dbus_pair_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dbus_port_defs.vh"
module dbus_pair_chk #(
  parameter WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [WIDTH-1:0] reg_rdata,
  input wire logic hw_standby,
  input wire logic dbus_drive,
  input wire logic [WIDTH-1:0] hi_lane_pins_oe_n,
  input wire logic [WIDTH-1:0] hi_lane_pullup_on,
  input wire logic [WIDTH-1:0] lo_lane_pins_oe_n,
  input wire logic [WIDTH-1:0] lo_lane_pullup_on,
  input wire logic hi_lane_bus_mode,
  input wire logic lo_lane_bus_mode
);
  // One clock domain, one reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Read data stands only in the cycle after the strobe
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read cycle");
  chk_dir_read: assert property ($past(reg_rd) &&
    ($past(reg_addr) == `HI_LANE_DIRECTION_ADDR ||
    $past(reg_addr) == `LO_LANE_DIRECTION_ADDR) |->
    reg_rdata == `UNDEFINED_READ)
    else $error("direction read not the fixed value");
  // Pull-ups only on input pins; guard rides out a direction change
  chk_hi_pu_input: assert property ($stable(hi_lane_pins_oe_n) |->
    (hi_lane_pullup_on & ~hi_lane_pins_oe_n) == '0)
    else $error("high pull-up on a driven pin");
  chk_lo_pu_input: assert property ($stable(lo_lane_pins_oe_n) |->
    (lo_lane_pullup_on & ~lo_lane_pins_oe_n) == '0)
    else $error("low pull-up on a driven pin");
  chk_hi_bus_pu: assert property (hi_lane_bus_mode &&
    $past(hi_lane_bus_mode) |-> hi_lane_pullup_on == '0)
    else $error("high pull-up in bus mode");
  chk_lo_bus_pu: assert property (lo_lane_bus_mode &&
    $past(lo_lane_bus_mode) |-> lo_lane_pullup_on == '0)
    else $error("low pull-up in wide bus mode");
  chk_lo_needs_hi: assert property (lo_lane_bus_mode |->
    hi_lane_bus_mode)
    else $error("low lane on bus without high lane");
  chk_bus_oe: assert property (hi_lane_bus_mode &&
    $past(hi_lane_bus_mode) |->
    hi_lane_pins_oe_n == {WIDTH{!$past(dbus_drive)}})
    else $error("bus mode enable not from bus controller");
  chk_stby_off: assert property (hw_standby [*5] |->
    &hi_lane_pins_oe_n && &lo_lane_pins_oe_n &&
    hi_lane_pullup_on == '0 && lo_lane_pullup_on == '0)
    else $error("pins active in hardware standby");
endmodule // dbus_pair_chk
bind data_bus_port_pair dbus_pair_chk #(.WIDTH(WIDTH)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .hw_standby(hw_standby), .dbus_drive(dbus_drive),
  .hi_lane_pins_oe_n(hi_lane_pins_oe_n),
  .hi_lane_pullup_on(hi_lane_pullup_on),
  .lo_lane_pins_oe_n(lo_lane_pins_oe_n),
  .lo_lane_pullup_on(lo_lane_pullup_on),
  .hi_lane_bus_mode(hi_lane_bus_mode), .lo_lane_bus_mode(lo_lane_bus_mode));
`default_nettype wire

// ---- tb/pin_board_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_board_model #(
  parameter WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic [WIDTH-1:0] pins_out,
  input wire logic [WIDTH-1:0] oe_n,
  input wire logic [WIDTH-1:0] pullup_on,
  input wire logic [WIDTH-1:0] ext_val,
  input wire logic [WIDTH-1:0] ext_en,
  output logic [WIDTH-1:0] pins
);
  logic [WIDTH-1:0] float_pat = '0;
  // Released lines wander, so a stale level never reads back by luck
  always @(posedge core_clk)
    float_pat <= ~float_pat;
  // Device driver first, then the board, then the pull-up
  always_comb
    for (int i = 0; i < WIDTH; i++)
      pins[i] = !oe_n[i] ? pins_out[i] : ext_en[i] ? ext_val[i] :
        pullup_on[i] ? 1'b1 : float_pat[i];
endmodule // pin_board_model
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dbus_port_defs.vh"
module testbench;
  logic core_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic hw_standby = 1'h0, sw_standby = 1'h0, bus16_sel = 1'h0;
  logic dbus_drive = 1'h0, rd_d = 1'h0;
  logic [2:0] mode_pins = 3'h7;
  logic [15:0] reg_addr = 16'h0000, dbus_out_data = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, hi_ext = 8'h00, lo_ext = 8'h00;
  logic [7:0] hi_en = 8'hFF, lo_en = 8'hFF, d, he, le;
  logic [7:0] vals [4];
  logic [7:0] exp_q [$];
  wire [7:0] reg_rdata, hi_pins, lo_pins, hi_out, hi_oe_n, hi_pu;
  wire [7:0] lo_out, lo_oe_n, lo_pu;
  wire [15:0] dbus_in_data;
  wire hi_bus, lo_bus;
  int n_errors = 0, num_checks = 0;
  integer seed = 32'h7FAC;
  localparam logic [15:0] REGS [4] = '{`HI_LANE_LATCH_ADDR,
    `HI_LANE_PULLUP_ADDR, `LO_LANE_LATCH_ADDR, `LO_LANE_PULLUP_ADDR};
  data_bus_port_pair #(.WIDTH(8)) uut (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_pins(mode_pins),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .bus16_sel(bus16_sel),
    .dbus_out_data(dbus_out_data), .dbus_drive(dbus_drive),
    .dbus_in_data(dbus_in_data), .hi_lane_pins_in(hi_pins),
    .hi_lane_pins_out(hi_out), .hi_lane_pins_oe_n(hi_oe_n),
    .hi_lane_pullup_on(hi_pu), .lo_lane_pins_in(lo_pins),
    .lo_lane_pins_out(lo_out), .lo_lane_pins_oe_n(lo_oe_n),
    .lo_lane_pullup_on(lo_pu), .hi_lane_bus_mode(hi_bus),
    .lo_lane_bus_mode(lo_bus));
  pin_board_model #(.WIDTH(8)) hi_board (.core_clk(core_clk),
    .pins_out(hi_out), .oe_n(hi_oe_n), .pullup_on(hi_pu), .ext_val(hi_ext),
    .ext_en(hi_en), .pins(hi_pins));
  pin_board_model #(.WIDTH(8)) lo_board (.core_clk(core_clk),
    .pins_out(lo_out), .oe_n(lo_oe_n), .pullup_on(lo_pu), .ext_val(lo_ext),
    .ext_en(lo_en), .pins(lo_pins));
  ////////////////////////////////////////
  // Free-running core clock
  initial
    forever #2 core_clk = ~core_clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'h0;
  endtask
  task finish_test;
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Read data is only valid in the cycle after the strobe
  always @(posedge core_clk)
    rd_d <= reg_rd;
  always @(negedge core_clk)
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
  // Hang guard
  initial
  begin
    idle(20000);
    n_errors++;
    finish_test;
  end
  // Main sequence: registers, pin views, bus modes, standby
  initial
  begin
    idle(8);
    nrst <= 1'h1;
    for (int i = 0; i < 4; i++) rd(REGS[i], 8'h00);
    rd(`LO_LANE_DIRECTION_ADDR, `UNDEFINED_READ);
    rd(16'hFF00, `UNDEFINED_READ);
    chk(hi_oe_n & lo_oe_n, 8'hFF);
    for (int i = 0; i < 4; i++) vals[i] = $random(seed);
    for (int i = 0; i < 4; i++) wr(REGS[i], vals[i]);
    for (int i = 0; i < 4; i++) rd(REGS[i], vals[i]);
    d = $random(seed);
    wr(`HI_LANE_DIRECTION_ADDR, d);
    wr(`LO_LANE_DIRECTION_ADDR, ~d);
    hi_ext <= $random(seed);
    lo_ext <= $random(seed);
    hi_en <= ~vals[1];
    lo_en <= ~vals[3];
    idle(6);
    he = (vals[0] & d) | (~d & (vals[1] | hi_ext));
    le = (vals[2] & ~d) | (d & (vals[3] | lo_ext));
    chk(hi_oe_n, ~d);
    chk(hi_out & d, vals[0] & d);
    chk(hi_pu, vals[1] & ~d);
    chk(lo_oe_n, d);
    chk(lo_pu, vals[3] & d);
    chk(lo_out & ~d, vals[2] & ~d);
    wr(`HI_LANE_PIN_VIEW_ADDR, ~he);
    rd(`HI_LANE_PIN_VIEW_ADDR, he);
    rd(`LO_LANE_PIN_VIEW_ADDR, le);
    rd(`HI_LANE_LATCH_ADDR, vals[0]);
    sw_standby <= 1'h1;
    idle(2);
    hi_ext <= ~hi_ext;
    lo_ext <= ~lo_ext;
    idle(6);
    rd(`HI_LANE_PIN_VIEW_ADDR, he);
    rd(`LO_LANE_PIN_VIEW_ADDR, le);
    sw_standby <= 1'h0;
    mode_pins <= 3'h5;
    dbus_drive <= 1'h1;
    dbus_out_data <= $random(seed);
    idle(6);
    chk({hi_bus, lo_bus}, 8'h02);
    chk(hi_oe_n, 8'h00);
    chk(hi_out, dbus_out_data[15:8]);
    chk(hi_pu, 8'h00);
    chk(lo_oe_n, d);
    bus16_sel <= 1'h1;
    dbus_drive <= 1'h0;
    hi_en <= 8'hFF;
    lo_en <= 8'hFF;
    hi_ext <= $random(seed);
    lo_ext <= $random(seed);
    idle(6);
    chk({7'h00, lo_bus}, 8'h01);
    chk(lo_pu, 8'h00);
    chk(lo_out, dbus_out_data[7:0]);
    chk(lo_oe_n, 8'hFF);
    chk(dbus_in_data[15:8], hi_ext);
    chk(dbus_in_data[7:0], lo_ext);
    mode_pins <= 3'h7;
    bus16_sel <= 1'h0;
    idle(6);
    chk(hi_oe_n, ~d);
    hw_standby <= 1'h1;
    idle(6);
    rd(`HI_LANE_PIN_VIEW_ADDR, hi_ext);
    hw_standby <= 1'h0;
    idle(4);
    for (int i = 0; i < 4; i++) rd(REGS[i], 8'h00);
    chk(hi_oe_n & lo_oe_n, 8'hFF);
    rd(`HI_LANE_PIN_VIEW_ADDR, hi_ext);
    idle(4);
    finish_test;
  end
endmodule // testbench
`default_nettype wire
